// *** rtl/switch_forwarding_pkg.sv ***
package switch_forwarding_pkg;
	// Sizes
	localparam int NUM_PORTS = 9;
	localparam int PORT_W = 4;
	localparam int TABLE_ENTRIES = 2048;
	localparam int HASH_W = 11;
	localparam int BLOCK_BYTES = 512;
	localparam int NUM_BLOCKS = 160;
	localparam int BLK_W = 8;
	localparam int MAX_BLKS = 3;
	localparam int RESERVE_BLOCKS = 8;
	// Frame length limits in bytes
	localparam int MIN_LEN = 64;
	localparam int MAX_LEN_SHORT = 1518;
	localparam int MAX_LEN = 1522;
	localparam int MAX_LEN_TAG = 1526;
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int BIT_NS_100 = 10;
	localparam int BIT_NS_10 = 100;
	localparam int IPG_BITS = 96;
	localparam int IPG_SHORT_BITS = 92;
	localparam int SLOT_BITS = 512;
	localparam int IPG_CYC_100 = (IPG_BITS * BIT_NS_100 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IPG_CYC_10 = (IPG_BITS * BIT_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IPGS_CYC_100 = (IPG_SHORT_BITS * BIT_NS_100 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IPGS_CYC_10 = (IPG_SHORT_BITS * BIT_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOT_CYC_100 = (SLOT_BITS * BIT_NS_100 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOT_CYC_10 = (SLOT_BITS * BIT_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AGE_LIMIT_S = 300;
	localparam int AGE_STEP_S = 5;
	localparam int AGE_STEPS = AGE_LIMIT_S / AGE_STEP_S;
	localparam int AGE_TICK_CYC = AGE_STEP_S * (1000000000 / CLK_PERIOD_NS);
	localparam int STORM_WIN_MS = 50;
	localparam int STORM_WIN_CYC = STORM_WIN_MS * (1000000 / CLK_PERIOD_NS);
	localparam int STORM_FULL_100 = 7490;
	localparam int STORM_FULL_10 = 749;
	localparam int RETRY_LIMIT = 16;
	localparam int RESTART_RANGE = 10;
	localparam int BACKOFF_CAP = 10;
	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LOCK = 8'h04;
	localparam logic [7:0] REG_XOVER = 8'h08;
	localparam logic [7:0] REG_PVID_LO = 8'h0c;
	localparam logic [7:0] REG_PVID_HI = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_DROPS = 8'h18;
	localparam logic [7:0] REG_VLAN_BASE = 8'h40;
	// Control field positions and reset values
	localparam int CTRL_AGE_EN = 0;
	localparam int CTRL_STORM_EN = 1;
	localparam int CTRL_BYPASS = 2;
	localparam int CTRL_IPG92 = 3;
	localparam int CTRL_MAX1518 = 4;
	localparam int CTRL_RISE = 8;
	localparam int CTRL_FALL = 10;
	localparam logic [31:0] CTRL_RST = 32'h0000_0005;
	localparam logic [8:0] VLAN0_RST = 9'h1ff;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	// Special addresses
	localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
	localparam logic [47:0] BCAST_DA = 48'hffff_ffff_ffff;
	localparam logic [15:0] TPID_VLAN = 16'h8100;
	// One address table entry, eight bytes
	typedef struct packed {
		logic        valid;
		logic        locked;
		logic [3:0]  vlan;
		logic [3:0]  port;
		logic [5:0]  age;
		logic [47:0] mac;
	} entry_s;
endpackage

// *** rtl/switch_forwarding_engine.sv ***
// Summary of operation
// - Address table holds 2048 eight-byte entries: address, VLAN, port, age.
// - Frames are stored in 512-byte blocks chained together.
// - Each port has reserved blocks; all ports share the remaining pool.
// - Whole frame received and checksum verified before any forwarding.
// - Multicast or unknown unicast floods to other ports of the VLAN group.
// - Source lookup by hash; new addresses inserted only after error-free end.
// - Known source address gets its age counter cleared to zero.
// - No learning for frames sent to the PAUSE address.
// - Known unicast: drop if table port is ingress, else send there.
// - Egress only on ports sharing the source port VLAN group; with bypass off, tagged frames go to the group of their tag VID.
// - Forward reserved 00 and 02-0F group addresses, drop 01.
// - Entries idle 300 seconds are removed when aging enabled; aging can be off.
// - Truncated exponential back-off; restart counts 0-9 after 16 attempts.
// - Inter-frame gap of 96 bit times, optionally 92.
// - Drop runts, oversize and bad checksum frames; accept good dribble frames.
// - Bypass limit 1522; otherwise tagged 1526, untagged 1518 when selected, else 1522.
// - Half duplex with strap on: jam when no receive buffer available.
// - Full duplex without buffer sends PAUSE; received PAUSE is honoured.
// - Count broadcasts per 50 ms window; discard above rising threshold.
// - Two-bit codes select rising and falling percentages by port mix.
// - Crossover forced by strap, else enabled per port bit.
// - Locked port keeps first address, no aging, drops other sources.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module switch_forwarding_engine
	import switch_forwarding_pkg::*;
#(
	parameter int AGE_TICK = AGE_TICK_CYC,
	parameter int STORM_WIN = STORM_WIN_CYC,
	parameter int RESERVE = RESERVE_BLOCKS
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	// Register port
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_we_i,
	input  wire logic                 reg_re_i,
	output logic      [31:0]          reg_rdata_o,
	// Ingress byte stream
	input  wire logic                 in_valid_i,
	input  wire logic [PORT_W-1:0]    in_port_i,
	input  wire logic [7:0]           in_data_i,
	input  wire logic                 in_last_i,
	input  wire logic                 in_fcs_ok_i,
	// Port status and straps
	input  wire logic [NUM_PORTS-1:0] full_duplex_i,
	input  wire logic [NUM_PORTS-1:0] speed_100_i,
	input  wire logic                 backpressure_strap_i,
	input  wire logic                 xover_strap_i,
	output logic      [NUM_PORTS-1:0] mdix_en_o,
	// Flow control
	output logic      [NUM_PORTS-1:0] jam_o,
	output logic      [NUM_PORTS-1:0] pause_tx_o,
	input  wire logic [NUM_PORTS-1:0] pause_rx_i,
	input  wire logic [15:0]          pause_quanta_i,
	// Transmit pacing
	input  wire logic [NUM_PORTS-1:0] tx_end_i,
	input  wire logic [NUM_PORTS-1:0] tx_col_i,
	output logic      [NUM_PORTS-1:0] tx_ok_o,
	// Forwarding decision
	output logic                      fwd_valid_o,
	output logic      [NUM_PORTS-1:0] fwd_mask_o,
	output logic      [BLK_W-1:0]     fwd_head_o,
	output logic      [10:0]          fwd_len_o,
	output logic      [PORT_W-1:0]    fwd_src_o,
	// Buffer read and release
	input  wire logic [BLK_W-1:0]     buf_rd_block_i,
	input  wire logic [8:0]           buf_rd_off_i,
	output logic      [7:0]           buf_rd_data_o,
	output logic      [BLK_W-1:0]     buf_next_o,
	input  wire logic                 rel_valid_i,
	input  wire logic [BLK_W-1:0]     rel_block_i,
	input  wire logic [PORT_W-1:0]    rel_port_i
);

typedef struct packed {
	logic [31:0]                        ctrl;
	logic [NUM_PORTS-1:0]               lock_en;
	logic [NUM_PORTS-1:0]               xover;
	logic [NUM_PORTS-1:0][3:0]          pvid;
	logic [15:0][NUM_PORTS-1:0]         vmap;
	logic [31:0]                        drops;
	logic [31:0]                        rdata;
	logic                               bp_en;
	logic                               bp_done;
	logic                               rx_on;
	logic                               rx_bad;
	logic [10:0]                        len;
	logic [MAX_BLKS-1:0][BLK_W-1:0]     blk;
	logic [1:0]                         nblk;
	logic [47:0]                        da;
	logic [47:0]                        sa;
	logic [15:0]                        tpid;
	logic [3:0]                         vid;
	logic [NUM_BLOCKS-1:0]              free;
	logic [NUM_PORTS-1:0][BLK_W-1:0]    used;
	logic [NUM_PORTS-1:0]               lock_have;
	logic [NUM_PORTS-1:0][47:0]         lock_mac;
	logic [NUM_PORTS-1:0][12:0]         bc_cnt;
	logic [NUM_PORTS-1:0]               storm;
	logic [31:0]                        win;
	logic [31:0]                        age_tmr;
	logic                               init;
	logic                               sweep_on;
	logic [HASH_W-1:0]                  sweep;
	logic [NUM_PORTS-1:0][8:0]          gap;
	logic [NUM_PORTS-1:0][11:0]         tmr;
	logic [NUM_PORTS-1:0][15:0]         slots;
	logic [NUM_PORTS-1:0][4:0]          att;
	logic [15:0]                        lfsr;
	logic                               fwd_valid;
	logic [NUM_PORTS-1:0]               mask;
	logic [BLK_W-1:0]                   head;
	logic [10:0]                        flen;
	logic [PORT_W-1:0]                  src;
	logic [NUM_PORTS-1:0]               jam;
	logic [NUM_PORTS-1:0]               pause_tx;
} state_s;

state_s s;
state_s next_s;

// Memories and their write controls
entry_s            tbl_mem [TABLE_ENTRIES];
logic [7:0]        data_mem [NUM_BLOCKS*BLOCK_BYTES];
logic [BLK_W-1:0]  link_mem [NUM_BLOCKS];
logic              tbl_we;
logic [HASH_W-1:0] tbl_wa;
entry_s            tbl_wd;
logic              mem_we;
logic [16:0]       mem_wa;
logic              link_we;
logic [BLK_W-1:0]  link_wa;
logic [BLK_W-1:0]  link_wd;

// Decision helpers
entry_s            rd_da;
entry_s            rd_sa;
entry_s            rd_sw;
logic [BLK_W-1:0]  pick;
logic [BLK_W-1:0]  free_cnt;
logic [BLK_W-1:0]  owed;
logic [PORT_W-1:0] p;
logic [10:0]       cur;
logic              can_alloc;
logic [10:0]       lim;
logic              good;
logic [3:0]        grp;
logic [NUM_PORTS-1:0] vmask;
logic [NUM_PORTS-1:0] dmask;
logic              bcast;
logic              lock_bad;
logic              storm_drop;
logic              all100;
logic [4:0]        k;
logic [3:0]        nib;
logic [1:0]        bi;

// Fold the address into the table index
function automatic logic [HASH_W-1:0] hash(input logic [47:0] m);
	hash = m[10:0] ^ m[21:11] ^ m[32:22] ^ m[43:33] ^ {7'h00, m[47:44]};
endfunction

// Storm threshold in frames per window, from percent in tenths
function automatic logic [12:0] thr(input logic [1:0] code, input logic rise,
		input logic mix100, input logic fast);
	logic [31:0] tenths;
	logic [31:0] full;
	tenths = rise ? (mix100 ? 32'd100 : 32'd10) : (mix100 ? 32'd50 : 32'd5);
	full = fast ? STORM_FULL_100 : STORM_FULL_10;
	tenths = (code == 2'd0) ? 32'd0 : tenths << (code - 2'd1);
	thr = 13'((full * tenths) / 32'd1000);
endfunction

assign rd_da = tbl_mem[hash(s.da)];
assign rd_sa = tbl_mem[hash(s.sa)];
assign rd_sw = tbl_mem[s.sweep];

////////////////////////////////////////////////////////////////////////////////
// Next state
always_comb begin
	next_s = s;
	tbl_we = 1'b0;
	tbl_wa = '0;
	tbl_wd = '0;
	mem_we = 1'b0;
	mem_wa = '0;
	link_we = 1'b0;
	link_wa = '0;
	link_wd = '0;
	pick = '0;
	free_cnt = '0;
	owed = '0;
	k = '0;
	next_s.fwd_valid = 1'b0;
	next_s.jam = '0;
	next_s.pause_tx = '0;
	next_s.rdata = '0;
	next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
	nib = (s.lfsr[3:0] >= 4'(RESTART_RANGE)) ? s.lfsr[3:0] - 4'(RESTART_RANGE) : s.lfsr[3:0];
	all100 = &speed_100_i;
	// Strap is caught on the first edge after reset release
	// strap capture
	if (!s.bp_done) begin
		next_s.bp_en = backpressure_strap_i;
		next_s.bp_done = 1'b1;
	end
	// Register writes and reads
	if (reg_we_i) begin
		if (reg_addr_i == REG_CTRL) begin
			next_s.ctrl = reg_wdata_i;
		end else if (reg_addr_i == REG_LOCK) begin
			next_s.lock_en = reg_wdata_i[NUM_PORTS-1:0];
		end else if (reg_addr_i == REG_XOVER) begin
			next_s.xover = reg_wdata_i[NUM_PORTS-1:0];
		end else if (reg_addr_i == REG_PVID_LO) begin
			next_s.pvid[7:0] = reg_wdata_i;
		end else if (reg_addr_i == REG_PVID_HI) begin
			next_s.pvid[8] = reg_wdata_i[3:0];
		end else if (reg_addr_i[7:6] == REG_VLAN_BASE[7:6] && reg_addr_i[1:0] == 2'd0) begin
			next_s.vmap[reg_addr_i[5:2]] = reg_wdata_i[NUM_PORTS-1:0];
		end
	end
	// Buffer pool accounting
	// shared pool sizing
	for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
		if (s.free[i]) begin
			pick = BLK_W'(i);
		end
		free_cnt = free_cnt + BLK_W'(s.free[i]);
	end
	for (int i = 0; i < NUM_PORTS; i++) begin
		if (s.used[i] < BLK_W'(RESERVE)) begin
			owed = owed + (BLK_W'(RESERVE) - s.used[i]);
		end
	end
	if (reg_re_i) begin
		if (reg_addr_i == REG_CTRL) begin
			next_s.rdata = s.ctrl;
		end else if (reg_addr_i == REG_LOCK) begin
			next_s.rdata = 32'(s.lock_en);
		end else if (reg_addr_i == REG_XOVER) begin
			next_s.rdata = 32'(s.xover);
		end else if (reg_addr_i == REG_PVID_LO) begin
			next_s.rdata = s.pvid[7:0];
		end else if (reg_addr_i == REG_PVID_HI) begin
			next_s.rdata = 32'(s.pvid[8]);
		end else if (reg_addr_i == REG_STATUS) begin
			next_s.rdata = {4'h0, s.init, s.bp_en, s.lock_have, s.storm, free_cnt};
		end else if (reg_addr_i == REG_DROPS) begin
			next_s.rdata = s.drops;
		end else if (reg_addr_i[7:6] == REG_VLAN_BASE[7:6] && reg_addr_i[1:0] == 2'd0) begin
			next_s.rdata = 32'(s.vmap[reg_addr_i[5:2]]);
		end
	end
	// Blocks handed back after egress
	if (rel_valid_i) begin
		next_s.free[rel_block_i] = 1'b1;
		if (s.used[rel_port_i] != '0) begin
			next_s.used[rel_port_i] = s.used[rel_port_i] - 1'b1;
		end
	end
	// Storm window end: release ports at or below the falling level
	// window restart
	if (s.win == 32'(STORM_WIN - 1)) begin
		next_s.win = '0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (s.bc_cnt[i] <= thr(s.ctrl[CTRL_FALL+:2], 1'b0, all100, speed_100_i[i])) begin
				next_s.storm[i] = 1'b0;
			end
			next_s.bc_cnt[i] = '0;
		end
	end else begin
		next_s.win = s.win + 1'b1;
	end
	// Ingress: one byte per valid cycle
	p = in_port_i;
	cur = s.rx_on ? s.len : 11'd0;
	can_alloc = (free_cnt != '0) && (s.used[p] < BLK_W'(RESERVE) || free_cnt > owed);
	bi = cur[10:9];
	lim = 11'(MAX_LEN);
	good = 1'b0;
	grp = '0;
	vmask = '0;
	dmask = '0;
	bcast = 1'b0;
	lock_bad = 1'b0;
	storm_drop = 1'b0;
	if (in_valid_i) begin
		if (!s.rx_on) begin
			next_s.rx_bad = 1'b0;
			next_s.nblk = '0;
			next_s.tpid = '0;
		end
		if (cur[8:0] == 9'd0 && cur < 11'(MAX_BLKS * BLOCK_BYTES) && !next_s.rx_bad) begin
			if (can_alloc) begin
				next_s.free[pick] = 1'b0;
				next_s.used[p] = next_s.used[p] + 1'b1;
				next_s.blk[bi] = pick;
				next_s.nblk = bi + 2'd1;
				link_we = (bi != 2'd0);
				link_wa = s.blk[(bi == 2'd0) ? 2'd0 : bi - 2'd1];
				link_wd = pick;
			end else begin
				next_s.rx_bad = 1'b1;
				next_s.jam[p] = !s.rx_on && !full_duplex_i[p] && s.bp_en;
				next_s.pause_tx[p] = !s.rx_on && full_duplex_i[p];
			end
		end
		mem_we = !next_s.rx_bad && cur < 11'(MAX_BLKS * BLOCK_BYTES);
		mem_wa = {next_s.blk[bi], cur[8:0]};
		// Header capture
		if (cur < 11'd6) begin
			next_s.da = {s.da[39:0], in_data_i};
		end else if (cur < 11'd12) begin
			next_s.sa = {s.sa[39:0], in_data_i};
		end else if (cur < 11'd14) begin
			next_s.tpid = {next_s.tpid[7:0], in_data_i};
		end else if (cur == 11'd15) begin
			next_s.vid = in_data_i[3:0];
		end
		next_s.len = (cur == 11'h7ff) ? cur : cur + 1'b1;
		next_s.rx_on = !in_last_i;
	end
	// Frame end: decide, learn or free
	if (in_valid_i && in_last_i) begin
		if (s.ctrl[CTRL_BYPASS]) begin
			lim = 11'(MAX_LEN);
		end else if (s.tpid == TPID_VLAN) begin
			lim = 11'(MAX_LEN_TAG);
		end else if (s.ctrl[CTRL_MAX1518]) begin
			lim = 11'(MAX_LEN_SHORT);
		end
		good = in_fcs_ok_i && !next_s.rx_bad && next_s.len >= 11'(MIN_LEN) && next_s.len <= lim;
		grp = (!s.ctrl[CTRL_BYPASS] && s.tpid == TPID_VLAN) ? s.vid : s.pvid[p];
		vmask = s.vmap[grp] & ~(NUM_PORTS'(1) << p);
		dmask = vmask;
		if (!s.da[40] && rd_da.valid && rd_da.mac == s.da) begin
			dmask = (rd_da.port == p) ? '0 : vmask & (NUM_PORTS'(1) << rd_da.port);
		end
		if (s.da == PAUSE_DA) begin
			dmask = '0;
		end
		lock_bad = s.lock_en[p] && s.lock_have[p] && s.sa != s.lock_mac[p];
		bcast = (s.da == BCAST_DA);
		if (bcast && s.ctrl[CTRL_STORM_EN] && s.ctrl[CTRL_RISE+:2] != 2'd0) begin
			next_s.bc_cnt[p] = (&next_s.bc_cnt[p]) ? next_s.bc_cnt[p] : next_s.bc_cnt[p] + 1'b1;
			if (s.storm[p] || s.bc_cnt[p] >= thr(s.ctrl[CTRL_RISE+:2], 1'b1, all100,
					speed_100_i[p])) begin
				storm_drop = 1'b1;
				next_s.storm[p] = 1'b1;
			end
		end
		if (good && !lock_bad && !storm_drop && dmask != '0) begin
			next_s.fwd_valid = 1'b1;
			next_s.mask = dmask;
			next_s.head = next_s.blk[0];
			next_s.flen = next_s.len;
			next_s.src = p;
		end else begin
			for (int i = 0; i < MAX_BLKS; i++) begin
				if (2'(i) < next_s.nblk) begin
					next_s.free[next_s.blk[i]] = 1'b1;
					next_s.used[p] = next_s.used[p] - 1'b1;
				end
			end
			next_s.drops = s.drops + 1'b1;
		end
		if (good && !lock_bad && s.da != PAUSE_DA && !s.sa[40] && !s.init) begin
			tbl_wa = hash(s.sa);
			tbl_wd = rd_sa;
			if (rd_sa.valid && rd_sa.mac == s.sa) begin
				tbl_we = 1'b1;
				tbl_wd.age = '0;
				tbl_wd.port = p;
				tbl_wd.vlan = grp;
			end else if (!(rd_sa.valid && rd_sa.locked)) begin
				tbl_we = 1'b1;
				tbl_wd = '{valid: 1'b1, locked: 1'b0, vlan: grp, port: p, age: 6'h00, mac: s.sa};
			end
			if (s.lock_en[p] && !s.lock_have[p] && tbl_we) begin
				next_s.lock_have[p] = 1'b1;
				next_s.lock_mac[p] = s.sa;
				tbl_wd.locked = 1'b1;
			end
		end
	end
	// Aging sweep, yields to learning
	if (s.age_tmr == 32'(AGE_TICK - 1)) begin
		next_s.age_tmr = '0;
		next_s.sweep_on = s.ctrl[CTRL_AGE_EN] || s.sweep_on;
	end else begin
		next_s.age_tmr = s.age_tmr + 1'b1;
	end
	if (s.sweep_on && !tbl_we) begin
		tbl_we = s.init || (rd_sw.valid && !rd_sw.locked);
		tbl_wa = s.sweep;
		tbl_wd = rd_sw;
		if (s.init || rd_sw.age >= 6'(AGE_STEPS - 1)) begin
			tbl_wd = '0;
		end else begin
			tbl_wd.age = rd_sw.age + 1'b1;
		end
		next_s.sweep = s.sweep + 1'b1;
		if (&s.sweep) begin
			next_s.sweep_on = 1'b0;
			next_s.init = 1'b0;
		end
	end
	// Per-port transmit pacing
	for (int i = 0; i < NUM_PORTS; i++) begin
		if (s.gap[i] != '0) begin
			next_s.gap[i] = s.gap[i] - 1'b1;
		end
		if (s.slots[i] != '0) begin
			if (s.tmr[i] == 12'(speed_100_i[i] ? SLOT_CYC_100 - 1 : SLOT_CYC_10 - 1)) begin
				next_s.tmr[i] = '0;
				next_s.slots[i] = s.slots[i] - 1'b1;
			end else begin
				next_s.tmr[i] = s.tmr[i] + 1'b1;
			end
		end
		if (tx_end_i[i] || tx_col_i[i]) begin
			if (s.ctrl[CTRL_IPG92]) begin
				next_s.gap[i] = 9'(speed_100_i[i] ? IPGS_CYC_100 : IPGS_CYC_10);
			end else begin
				next_s.gap[i] = 9'(speed_100_i[i] ? IPG_CYC_100 : IPG_CYC_10);
			end
		end
		if (tx_end_i[i]) begin
			next_s.att[i] = '0;
		end
		if (tx_col_i[i]) begin
			next_s.att[i] = (s.att[i] == 5'(RETRY_LIMIT - 1)) ? 5'(nib) : s.att[i] + 1'b1;
			k = (next_s.att[i] > 5'(BACKOFF_CAP)) ? 5'(BACKOFF_CAP) : next_s.att[i];
			next_s.slots[i] = s.lfsr & ((16'h0001 << k) - 16'h0001);
			next_s.tmr[i] = '0;
		end
		if (pause_rx_i[i]) begin
			next_s.slots[i] = pause_quanta_i;
			next_s.tmr[i] = '0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// State register
always_ff @(posedge clk_i) begin
	if (!nrst_i) begin
		s <= '0;
		s.ctrl <= CTRL_RST;
		s.vmap[0] <= VLAN0_RST;
		s.free <= '1;
		s.lfsr <= LFSR_SEED;
		s.init <= 1'b1;
		s.sweep_on <= 1'b1;
	end else begin
		s <= next_s;
	end
end

// Memories carry no reset; the table is cleared by the init sweep
// address table, frame data and block link storage
always_ff @(posedge clk_i) begin
	if (tbl_we) begin
		tbl_mem[tbl_wa] <= tbl_wd;
	end
	if (mem_we) begin
		data_mem[mem_wa] <= in_data_i;
	end
	if (link_we) begin
		link_mem[link_wa] <= link_wd;
	end
	buf_rd_data_o <= data_mem[{buf_rd_block_i, buf_rd_off_i}];
	buf_next_o <= link_mem[buf_rd_block_i];
end

////////////////////////////////////////////////////////////////////////////////
// Outputs
assign reg_rdata_o = s.rdata;
assign mdix_en_o = {NUM_PORTS{xover_strap_i}} | s.xover;
assign jam_o = s.jam;
assign pause_tx_o = s.pause_tx;
always_comb begin
	for (int i = 0; i < NUM_PORTS; i++) begin
		tx_ok_o[i] = (s.gap[i] == '0) && (s.slots[i] == '0);
	end
end
assign fwd_valid_o = s.fwd_valid;
assign fwd_mask_o = s.mask;
assign fwd_head_o = s.head;
assign fwd_len_o = s.flen;
assign fwd_src_o = s.src;

endmodule

// *** verification/switch_forwarding_assertions.sv ***
`timescale 1ns/1ps
module switch_forwarding_assertions
	import switch_forwarding_pkg::*;
(
	// Clock and reset
	input wire logic                 clk_i,
	input wire logic                 nrst_i,
	// Stimulus side
	input wire logic                 in_valid_i,
	input wire logic                 in_last_i,
	input wire logic                 in_fcs_ok_i,
	input wire logic [NUM_PORTS-1:0] full_duplex_i,
	input wire logic                 xover_strap_i,
	input wire logic [NUM_PORTS-1:0] tx_end_i,
	// Design outputs
	input wire logic [NUM_PORTS-1:0] mdix_en_o,
	input wire logic [NUM_PORTS-1:0] jam_o,
	input wire logic [NUM_PORTS-1:0] pause_tx_o,
	input wire logic [NUM_PORTS-1:0] tx_ok_o,
	input wire logic                 fwd_valid_o,
	input wire logic [NUM_PORTS-1:0] fwd_mask_o,
	input wire logic [PORT_W-1:0]    fwd_src_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic [6:0] seen;
	// Bytes before the current one; saturates so giants never wrap to runts
	always_ff @(posedge clk_i) begin
		if (!nrst_i || (in_valid_i && in_last_i))
			seen <= 7'h00;
		else if (in_valid_i && seen != 7'h7f)
			seen <= seen + 7'h01;
	end
	// Last byte of a frame
	sequence s_end;
		in_valid_i && in_last_i;
	endsequence
	a_fwd_after_end: assert property (fwd_valid_o |-> $past(in_last_i))
		else $error("forward without a frame end");
	a_bad_fcs_drop: assert property (s_end ##0 !in_fcs_ok_i |=> !fwd_valid_o)
		else $error("bad checksum frame forwarded");
	a_runt_drop: assert property (s_end ##0 (seen < 7'h3f) |=> !fwd_valid_o)
		else $error("runt frame forwarded");
	a_fwd_no_self: assert property (fwd_valid_o |-> !fwd_mask_o[fwd_src_o])
		else $error("frame sent back to ingress");
	a_mdix_strap: assert property (xover_strap_i |-> mdix_en_o == 9'h1ff)
		else $error("crossover not forced");
	a_jam_half: assert property (|jam_o |-> (jam_o & $past(full_duplex_i)) == 9'h000)
		else $error("jam on full duplex port");
	a_pause_full: assert property ((pause_tx_o & ~$past(full_duplex_i)) == '0)
		else $error("pause on half duplex port");
	a_gap_hold: assert property (tx_end_i[0] |=> !tx_ok_o[0] [*8])
		else $error("gap too short");
endmodule
bind switch_forwarding_engine switch_forwarding_assertions u_chk (.*);

// *** verification/eth_station.sv ***
`timescale 1ns/1ps
module eth_station
	import switch_forwarding_pkg::*;
(
	// Clock
	input  wire logic              clk_i,
	// Bytes towards the switch
	output logic                   in_valid_o,
	output logic [PORT_W-1:0]      in_port_o,
	output logic [7:0]             in_data_o,
	output logic                   in_last_o,
	output logic                   in_fcs_ok_o
);
	integer seed = 10;
	initial {in_valid_o, in_port_o, in_data_o, in_last_o, in_fcs_ok_o} = '0;
	// Header goes out most significant byte first, payload is random
	task automatic send(input int p, input logic [95:0] hdr, input int len, input bit ok);
		for (int i = 0; i < len; i++) begin
			@(posedge clk_i);
			in_valid_o <= 1'b1;
			in_port_o <= p[PORT_W-1:0];
			in_data_o <= (i < 12) ? hdr[95-8*i -: 8] : 8'($random(seed));
			in_last_o <= (i == len - 1);
			in_fcs_ok_o <= ok;
		end
		@(posedge clk_i);
		in_valid_o <= 1'b0;
		in_last_o <= 1'b0;
		// Idle lines show the inverse so stale bytes are never mistaken
		in_data_o <= ~in_data_o;
	endtask
endmodule

// *** verification/tb_switch_forwarding_engine.sv ***
`timescale 1ns/1ps
module tb_switch_forwarding_engine import switch_forwarding_pkg::*;;
	logic        clk_i = 1'b0, nrst_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
	logic        rel_valid_i = 1'b0, xover_strap_i = 1'b0, backpressure_strap_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00, buf_rd_block_i = 8'h00, rel_block_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
	logic [15:0] pause_quanta_i = 16'h0001;
	logic [8:0]  full_duplex_i = 9'h1ff, speed_100_i = 9'h1ff, tx_end_i = 9'h000;
	logic [8:0]  pause_rx_i = 9'h000, tx_col_i = 9'h000, buf_rd_off_i = 9'h000;
	logic [8:0]  mdix_en_o, jam_o, pause_tx_o, tx_ok_o, fwd_mask_o;
	logic [7:0]  fwd_head_o, buf_rd_data_o, buf_next_o, in_data_i, blk;
	logic [3:0]  rel_port_i = 4'h0, fwd_src_o, in_port_i;
	logic        fwd_valid_o, in_valid_i, in_last_i, in_fcs_ok_i;
	logic [10:0] fwd_len_o;
	logic [47:0] a, b, c, d, own [int];
	int          bad_count = 0, total_checks = 0, vmap = 'h1ff, fc = 0, learned [logic [47:0]];
	bit          lock_on [int];
	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	// Flow-control pulses stand one cycle; latch those of port 6
	always @(negedge clk_i) fc <= fc | {jam_o[6], pause_tx_o[6]};
	switch_forwarding_engine #(.AGE_TICK(50), .STORM_WIN(200)) u_dut (.*);
	eth_station u_st (.clk_i(clk_i), .in_valid_o(in_valid_i), .in_port_o(in_port_i),
		.in_data_o(in_data_i), .in_last_o(in_last_i), .in_fcs_ok_o(in_fcs_ok_i));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Register write or read; for a read dt is the expected value
	task automatic bus(input bit w, input logic [7:0] ad, input logic [31:0] dt);
		@(posedge clk_i);
		{reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} <= {w, !w, ad, dt};
		@(posedge clk_i);
		{reg_we_i, reg_re_i} <= 2'b00;
		@(negedge clk_i);
		if (!w) check(reg_rdata_o, dt);
	endtask
	// Reference decision; learning happens only for clean frames
	function automatic logic [8:0] model(int p, logic [47:0] da, logic [47:0] sa, int n, bit ok);
		logic [8:0] m = 9'h000;
		if (!ok || n < MIN_LEN || n > MAX_LEN || da == PAUSE_DA) return m;
		if (lock_on.exists(p) && own.exists(p) && own[p] != sa) return m;
		if (da[40] || !learned.exists(da)) m = vmap & ~(9'h001 << p);
		else if (learned[da] != p) m = vmap & (9'h001 << learned[da]);
		if (!sa[40]) learned[sa] = p;
		if (lock_on.exists(p) && !own.exists(p)) own[p] = sa;
		return m;
	endfunction
	// Send, compare decision, walk and free the block chain
	task automatic frame(int p, logic [47:0] da, logic [47:0] sa, int n, bit ok);
		logic [8:0] m = model(p, da, sa, n, ok);
		bit hit = 0;
		u_st.send(p, {da, sa}, n, ok);
		for (int i = 0; i < 4 && !hit; i++) begin
			@(negedge clk_i);
			hit = (fwd_valid_o === 1'b1);
		end
		check(hit ? fwd_mask_o : 9'h000, m);
		if (!hit) return;
		check(fwd_len_o, n);
		blk = fwd_head_o;
		for (int k = 0; k <= (n - 1) / BLOCK_BYTES; k++) begin
			@(posedge clk_i);
			{rel_valid_i, buf_rd_block_i} <= {1'b0, blk};
			repeat (2) @(posedge clk_i);
			{rel_valid_i, rel_block_i, rel_port_i} <= {1'b1, blk, 4'(p)};
			@(negedge clk_i);
			if (k == 0) check(buf_rd_data_o, da[47:40]);
			blk = buf_next_o;
		end
		@(posedge clk_i);
		rel_valid_i <= 1'b0;
	endtask
	// Pulse end of frame or pause, count cycles with transmit held off
	task automatic pace(int p, bit pz, int lo);
		int n = 0;
		@(posedge clk_i);
		{tx_end_i[p], pause_rx_i[p]} <= {!pz, pz};
		@(posedge clk_i);
		{tx_end_i, pause_rx_i} <= '0;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk_i);
			n += (tx_ok_o[p] === 1'b0);
		end
		check(n, lo);
	endtask
	// Hang guard: 100000 cycles
	initial begin
		#2_500_000;
		bad_count++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (2100) @(posedge clk_i);
		bus(0, REG_CTRL, CTRL_RST);
		bus(0, 8'h3c, 32'h0000_0000);
		bus(0, REG_VLAN_BASE, 32'(VLAN0_RST));
		a = 48'({$random(u_st.seed), $random(u_st.seed)}) & 48'hfeff_ffff_ffff;
		b = a ^ 48'h0000_0000_0101;
		c = a ^ 48'h0000_0000_0202;
		d = a ^ 48'h0000_0000_0404;
		frame(1, b, a, 64, 1);
		frame(2, a, b, 100, 1);
		frame(2, b, c, 64, 1);
		frame(1, b, a, 63, 1);
		frame(1, b, a, 64, 0);
		frame(1, b, a, MAX_LEN + 1, 1);
		frame(1, b, a, MAX_LEN, 1);
		$display("test unicast and illegal frames done");
		for (int i = 0; i < 16; i++) frame(4, 48'h0180_c200_0000 + i, c, 64, 1);
		frame(5, PAUSE_DA, d, 64, 1);
		frame(1, d, a, 64, 1);
		$display("test reserved groups done");
		bus(1, REG_LOCK, 32'h0000_0008);
		lock_on[3] = 1;
		frame(3, a, d, 64, 1);
		frame(3, a, c, 64, 1);
		bus(1, REG_CTRL, CTRL_RST ^ 32'h0000_0001);
		frame(1, b, a, 64, 1);
		bus(1, REG_VLAN_BASE, 32'h0000_0006);
		vmap = 'h006;
		frame(1, d ^ 48'h0000_0000_0808, a, 64, 1);
		$display("test locking aging vlan done");
		bus(1, REG_XOVER, 32'h0000_0001);
		check(mdix_en_o, 9'h001);
		@(posedge clk_i) xover_strap_i <= 1'b1;
		@(negedge clk_i);
		check(mdix_en_o, 9'h1ff);
		pace(0, 0, IPG_CYC_100);
		bus(1, REG_CTRL, CTRL_RST | 32'h0000_0008);
		pace(0, 0, IPGS_CYC_100);
		pace(2, 1, SLOT_CYC_100);
		repeat (97) u_st.send(6, {BCAST_DA, c}, 64, 1);
		full_duplex_i[6] <= 1'b0;
		u_st.send(6, {BCAST_DA, c}, 64, 1);
		check(fc, 32'h0000_0003);
		$display("test crossover and pacing done");
		final_report();
	end
endmodule
